// ===== design/ffr_flash_seq.v
// Functional notes
// - Dual read moves address and data on two lines
// - Control nibble A skips next dual command
// - Other nibble or reset sequence restores commands
// - Low control nibble is ignored
// - Quad read needs quad enable bit
// - Control byte clocks count as dummy clocks
// - Nibble A lets next quad read start with address
// - Wrap setup governs following quad read
// - Wrapped output loops inside aligned page section
// - Four-wire dummy clocks 4, 6 or 8
// - Continuous read works in four-wire mode too
// - No wrap for quad read in four-wire mode
// - Program accepted only with write permit set
// - Write permit command sets the latch when not busy
// - Program byte address wraps inside the page
// - Unloaded page bytes stay untouched
// - Program runs only on whole-byte frame end
// - Self-timed program, status reads still answered
// - Busy during program; latch cleared when busy
// - Quad program needs enable, four lines
// - Dummy field 00/01 four, 10 six, 11 eight
`include "ffr_defs.vh"

module ffr_flash_seq #(
	parameter [23:0] PROG_CYCLES = `FFR_PROG_CYCLES
) (
	// Clock and reset
	input wire clk_sys_i,
	input wire rst_b_i,
	// Link pins
	input wire link_cs_b_i,
	input wire link_sck_i,
	input wire [3:0] link_io_i,
	output reg [3:0] link_io_o,
	output reg [3:0] link_io_oe_o,
	// Configuration
	input wire quad_lines_enable_bit_i,
	input wire four_wire_command_mode_i,
	input wire wrap_enable_i,
	input wire [1:0] wrap_len_sel_i,
	input wire [1:0] dummy_sel_i,
	// Status
	output reg busy_o,
	output reg write_permit_latch_o,
	output reg continuous_read_o,
	// Array read
	output reg mem_rd_req_o,
	output reg [23:0] mem_rd_addr_o,
	input wire mem_rd_ack_i,
	input wire [7:0] mem_rd_data_i,
	// Array program
	output reg mem_wr_en_o,
	output reg [23:0] mem_wr_addr_o,
	output reg [7:0] mem_wr_data_o
);

	localparam [2:0] ST_IDLE = 3'h0;
	localparam [2:0] ST_CMD = 3'h1;
	localparam [2:0] ST_ADDR = 3'h2;
	localparam [2:0] ST_DUMMY = 3'h3;
	localparam [2:0] ST_DOUT = 3'h4;
	localparam [2:0] ST_DIN = 3'h5;
	localparam [2:0] ST_STAT = 3'h6;
	localparam [2:0] ST_SKIP = 3'h7;

	// ****************************************
	// Pin synchronisers
	// ****************************************
	// Stage three is compared to stage two so a glitch shorter than a
	// clock never becomes an edge.
	reg [5:0] sy1_reg;
	reg [5:0] sy2_reg;
	reg [5:0] sy3_reg;
	reg [5:0] syf_reg;
	wire [5:0] syf_next;
	assign syf_next = ((sy2_reg ~^ sy3_reg) & sy3_reg) |
		((sy2_reg ^ sy3_reg) & syf_reg);

	always @(posedge clk_sys_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			sy1_reg <= 6'h20;
			sy2_reg <= 6'h20;
			sy3_reg <= 6'h20;
			syf_reg <= 6'h20;
		end else begin
			sy1_reg <= {link_cs_b_i, link_sck_i, link_io_i};
			sy2_reg <= sy1_reg;
			sy3_reg <= sy2_reg;
			syf_reg <= syf_next;
		end
	end

	wire cs_fall = syf_reg[5] & ~syf_next[5];
	wire cs_rise = ~syf_reg[5] & syf_next[5];
	wire sck_rise = ~syf_reg[5] & ~syf_reg[4] & syf_next[4];
	wire sck_fall = ~syf_reg[5] & syf_reg[4] & ~syf_next[4];
	wire [3:0] io_s = syf_reg[3:0];

	// ****************************************
	// Frame state
	// ****************************************
	reg [2:0] state_reg;
	reg [2:0] lanes_reg;
	reg [23:0] sh_reg;
	reg [4:0] bits_reg;
	reg [3:0] dum_cnt_reg;
	reg [3:0] dum_tot_reg;
	reg is_quad_reg;
	reg is_prog_reg;
	reg crm_quad_reg;
	reg crm_frame_reg;
	reg ones_reg;
	reg [7:0] out_sh_reg;
	reg [2:0] out_cnt_reg;
	reg [15:0] pg_base_reg;
	reg [7:0] pg_idx_reg;
	reg byte_seen_reg;
	reg [255:0] pg_mask_reg;
	reg [7:0] pbuf_reg [0:255];
	reg [23:0] pc_cnt_reg;
	reg [8:0] wr_idx_reg;

	// ****************************************
	// Read path: requests and two-entry buffer
	// ****************************************
	reg [23:0] rd_addr_reg;
	reg rd_run_reg;
	reg rd_pend_reg;
	reg rd_drop_reg;
	reg rd_wrap_reg;
	reg [7:0] fb_data_reg [0:1];
	reg fb_wptr_reg;
	reg fb_rptr_reg;
	reg [1:0] fb_cnt_reg;
	wire fb_push = mem_rd_ack_i & rd_pend_reg & ~rd_drop_reg;
	wire fb_valid = (fb_cnt_reg != 2'h0);
	// Requests stop while a read is outstanding or the buffer is full
	wire fb_room = ~rd_pend_reg & (fb_cnt_reg != 2'h2);

	// ****************************************
	// Combinational helpers
	// ****************************************
	reg [23:0] sh_next;
	reg chunk_ones;
	reg [2:0] out_last;
	reg [7:0] wrap_mask;
	reg [7:0] out_byte;
	reg [3:0] out_io;
	reg [3:0] out_oe;
	reg [3:0] qpi_dummy;
	reg [23:0] rd_addr_next;
	reg fb_pop;
	wire [4:0] bits_next = bits_reg + {2'h0, lanes_reg};
	wire [7:0] status_byte = {`FFR_STATUS_PAD, write_permit_latch_o, busy_o};

	always @* begin
		case (lanes_reg)
			3'h1: begin
				sh_next = {sh_reg[22:0], io_s[0]};
				chunk_ones = io_s[0];
				out_last = 3'h7;
			end
			3'h2: begin
				sh_next = {sh_reg[21:0], io_s[1:0]};
				chunk_ones = &io_s[1:0];
				out_last = 3'h3;
			end
			default: begin
				sh_next = {sh_reg[19:0], io_s};
				chunk_ones = &io_s;
				out_last = 3'h1;
			end
		endcase
		case (wrap_len_sel_i)
			2'h0: wrap_mask = `FFR_WRAP_MASK_8;
			2'h1: wrap_mask = `FFR_WRAP_MASK_16;
			2'h2: wrap_mask = `FFR_WRAP_MASK_32;
			default: wrap_mask = `FFR_WRAP_MASK_64;
		endcase
		case (dummy_sel_i)
			2'h2: qpi_dummy = `FFR_QPI_DUMMY_6;
			2'h3: qpi_dummy = `FFR_QPI_DUMMY_8;
			default: qpi_dummy = `FFR_QPI_DUMMY_4;
		endcase
		// Section wrap keeps the upper address bits fixed
		if (rd_wrap_reg) begin
			rd_addr_next = {rd_addr_reg[23:8],
				(rd_addr_reg[7:0] & ~wrap_mask) |
				((rd_addr_reg[7:0] + 8'h01) & wrap_mask)};
		end else begin
			rd_addr_next = rd_addr_reg + 24'h000001;
		end
		fb_pop = 1'b0;
		out_byte = out_sh_reg;
		if (out_cnt_reg == 3'h0) begin
			if (state_reg == ST_STAT) begin
				out_byte = status_byte;
			end else if (fb_valid) begin
				out_byte = fb_data_reg[fb_rptr_reg];
				fb_pop = sck_fall & (state_reg == ST_DOUT);
			end else begin
				out_byte = `FFR_IDLE_BYTE;
			end
		end
		case (lanes_reg)
			3'h1: begin
				out_io = {2'h0, out_byte[7], 1'b0};
				out_oe = 4'h2;
			end
			3'h2: begin
				out_io = {2'h0, out_byte[7:6]};
				out_oe = 4'h3;
			end
			default: begin
				out_io = out_byte[7:4];
				out_oe = 4'hF;
			end
		endcase
	end

	// ****************************************
	// Page buffer storage
	// ****************************************
	wire pb_we = sck_rise & (state_reg == ST_DIN) &
		(bits_next == `FFR_CMD_BITS);
	always @(posedge clk_sys_i) begin
		if (pb_we) begin
			pbuf_reg[pg_idx_reg] <= sh_next[7:0];
		end
	end

	// ****************************************
	// Sequencer
	// ****************************************
	always @(posedge clk_sys_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			state_reg <= ST_IDLE;
			lanes_reg <= 3'h1;
			sh_reg <= 24'h000000;
			bits_reg <= 5'h00;
			dum_cnt_reg <= 4'h0;
			dum_tot_reg <= 4'h0;
			is_quad_reg <= 1'b0;
			is_prog_reg <= 1'b0;
			crm_quad_reg <= 1'b0;
			crm_frame_reg <= 1'b0;
			ones_reg <= 1'b0;
			out_sh_reg <= 8'h00;
			out_cnt_reg <= 3'h0;
			pg_base_reg <= 16'h0000;
			pg_idx_reg <= 8'h00;
			byte_seen_reg <= 1'b0;
			pg_mask_reg <= {256{1'b0}};
			pc_cnt_reg <= 24'h000000;
			wr_idx_reg <= 9'h000;
			rd_addr_reg <= 24'h000000;
			rd_run_reg <= 1'b0;
			rd_pend_reg <= 1'b0;
			rd_drop_reg <= 1'b0;
			rd_wrap_reg <= 1'b0;
			fb_data_reg[0] <= 8'h00;
			fb_data_reg[1] <= 8'h00;
			fb_wptr_reg <= 1'b0;
			fb_rptr_reg <= 1'b0;
			fb_cnt_reg <= 2'h0;
			link_io_o <= 4'h0;
			link_io_oe_o <= 4'h0;
			busy_o <= 1'b0;
			write_permit_latch_o <= 1'b0;
			continuous_read_o <= 1'b0;
			mem_rd_req_o <= 1'b0;
			mem_rd_addr_o <= 24'h000000;
			mem_wr_en_o <= 1'b0;
			mem_wr_addr_o <= 24'h000000;
			mem_wr_data_o <= 8'h00;
		end else begin
			// Array read requests feed the buffer
			mem_rd_req_o <= 1'b0;
			// A request launched at frame end would leave stale data behind
			if (rd_run_reg & fb_room & ~cs_rise) begin
				mem_rd_req_o <= 1'b1;
				mem_rd_addr_o <= rd_addr_reg;
				rd_addr_reg <= rd_addr_next;
				rd_pend_reg <= 1'b1;
			end else if (mem_rd_ack_i) begin
				rd_pend_reg <= 1'b0;
				rd_drop_reg <= 1'b0;
			end
			if (fb_push) begin
				fb_data_reg[fb_wptr_reg] <= mem_rd_data_i;
				fb_wptr_reg <= ~fb_wptr_reg;
			end
			if (fb_pop) begin
				fb_rptr_reg <= ~fb_rptr_reg;
			end
			fb_cnt_reg <= fb_cnt_reg + {1'b0, fb_push} - {1'b0, fb_pop};

			// Self-timed program cycle walks the loaded page
			mem_wr_en_o <= 1'b0;
			if (busy_o) begin
				pc_cnt_reg <= pc_cnt_reg + 24'h000001;
				if (!wr_idx_reg[8]) begin
					mem_wr_en_o <= pg_mask_reg[wr_idx_reg[7:0]];
					mem_wr_addr_o <= {pg_base_reg, wr_idx_reg[7:0]};
					mem_wr_data_o <= pbuf_reg[wr_idx_reg[7:0]];
					wr_idx_reg <= wr_idx_reg + 9'h001;
				end
				if (pc_cnt_reg == PROG_CYCLES - 24'h000001) begin
					busy_o <= 1'b0;
					pg_mask_reg <= {256{1'b0}};
				end
			end

			if (cs_fall) begin
				// Continuous read skips the command byte
				bits_reg <= 5'h00;
				ones_reg <= 1'b1;
				out_cnt_reg <= 3'h0;
				byte_seen_reg <= 1'b0;
				is_prog_reg <= 1'b0;
				crm_frame_reg <= continuous_read_o;
				is_quad_reg <= crm_quad_reg;
				if (continuous_read_o && !busy_o) begin
					state_reg <= ST_ADDR;
					lanes_reg <= crm_quad_reg ? 3'h4 : 3'h2;
				end else begin
					state_reg <= ST_CMD;
					lanes_reg <= four_wire_command_mode_i ? 3'h4 : 3'h1;
				end
			end else if (cs_rise) begin
				state_reg <= ST_IDLE;
				link_io_oe_o <= 4'h0;
				rd_run_reg <= 1'b0;
				rd_drop_reg <= rd_pend_reg & ~mem_rd_ack_i;
				fb_cnt_reg <= 2'h0;
				fb_rptr_reg <= fb_wptr_reg ^ fb_push;
				// All-ones clocked where the address is expected
				if (crm_frame_reg && state_reg == ST_ADDR && ones_reg) begin
					continuous_read_o <= 1'b0;
				end
				if (state_reg == ST_DIN && bits_reg == 5'h00 &&
					byte_seen_reg) begin
					busy_o <= 1'b1;
					write_permit_latch_o <= 1'b0;
					pc_cnt_reg <= 24'h000000;
					wr_idx_reg <= 9'h000;
				end else if (is_prog_reg) begin
					pg_mask_reg <= {256{1'b0}};
				end
			end else if (sck_rise) begin
				sh_reg <= sh_next;
				bits_reg <= bits_next;
				ones_reg <= ones_reg & chunk_ones;
				case (state_reg)
					ST_CMD: begin
						if (bits_next == `FFR_CMD_BITS) begin
							bits_reg <= 5'h00;
							state_reg <= ST_SKIP;
							case (sh_next[7:0])
								`FFR_CMD_WRITE_PERMIT: begin
									if (!busy_o) begin
										write_permit_latch_o <= 1'b1;
									end
								end
								`FFR_CMD_READ_STATUS: begin
									state_reg <= ST_STAT;
								end
								`FFR_CMD_DUAL_IO_READ: begin
									if (!busy_o && !four_wire_command_mode_i) begin
										state_reg <= ST_ADDR;
										lanes_reg <= 3'h2;
										is_quad_reg <= 1'b0;
									end
								end
								`FFR_CMD_QUAD_IO_READ: begin
									if (!busy_o && quad_lines_enable_bit_i) begin
										state_reg <= ST_ADDR;
										lanes_reg <= 3'h4;
										is_quad_reg <= 1'b1;
									end
								end
								`FFR_CMD_PAGE_PROGRAM: begin
									if (!busy_o && write_permit_latch_o) begin
										state_reg <= ST_ADDR;
										is_prog_reg <= 1'b1;
									end
								end
								`FFR_CMD_QUAD_PROGRAM: begin
									if (!busy_o && write_permit_latch_o &&
										quad_lines_enable_bit_i) begin
										state_reg <= ST_ADDR;
										lanes_reg <= 3'h4;
										is_prog_reg <= 1'b1;
									end
								end
								default: begin
									state_reg <= ST_SKIP;
								end
							endcase
						end
					end
					ST_ADDR: begin
						if (bits_next == `FFR_ADDR_BITS) begin
							bits_reg <= 5'h00;
							if (is_prog_reg) begin
								pg_base_reg <= sh_next[23:8];
								pg_idx_reg <= sh_next[7:0];
								state_reg <= ST_DIN;
							end else begin
								rd_addr_reg <= sh_next;
								rd_run_reg <= 1'b1;
								rd_wrap_reg <= is_quad_reg & wrap_enable_i &
									~four_wire_command_mode_i;
								dum_cnt_reg <= 4'h0;
								if (!is_quad_reg) begin
									dum_tot_reg <= `FFR_DUAL_DUMMY;
								end else if (four_wire_command_mode_i) begin
									dum_tot_reg <= qpi_dummy;
								end else begin
									dum_tot_reg <= `FFR_QUAD_SPI_DUMMY;
								end
								state_reg <= ST_DUMMY;
							end
						end
					end
					ST_DUMMY: begin
						// Control byte clocks are part of the dummy count
						dum_cnt_reg <= dum_cnt_reg + 4'h1;
						if (dum_cnt_reg == (is_quad_reg ? `FFR_QUAD_MODE_CLKS :
							`FFR_DUAL_MODE_CLKS) - 4'h1) begin
							continuous_read_o <=
								(sh_next[7:4] == `FFR_CRM_SELECT);
							crm_quad_reg <= is_quad_reg;
						end
						if (dum_cnt_reg == dum_tot_reg - 4'h1) begin
							state_reg <= ST_DOUT;
							out_cnt_reg <= 3'h0;
						end
					end
					ST_DIN: begin
						if (bits_next == `FFR_CMD_BITS) begin
							bits_reg <= 5'h00;
							byte_seen_reg <= 1'b1;
							pg_mask_reg[pg_idx_reg] <= 1'b1;
							pg_idx_reg <= pg_idx_reg + 8'h01;
						end
					end
					default: begin
						bits_reg <= 5'h00;
					end
				endcase
			end else if (sck_fall &&
				(state_reg == ST_DOUT || state_reg == ST_STAT)) begin
				// Lines are driven only from the first output falling edge
				link_io_o <= out_io;
				link_io_oe_o <= out_oe;
				out_sh_reg <= out_byte << lanes_reg;
				out_cnt_reg <= (out_cnt_reg == 3'h0) ? out_last :
					out_cnt_reg - 3'h1;
			end
		end
	end

endmodule

// ===== inc/ffr_defs.vh
`ifndef FFR_DEFS_VH
`define FFR_DEFS_VH

// ****************************************
// Command codes
// ****************************************
`define FFR_CMD_WRITE_PERMIT 8'h06
`define FFR_CMD_READ_STATUS 8'h05
`define FFR_CMD_DUAL_IO_READ 8'hBB
`define FFR_CMD_QUAD_IO_READ 8'hEB
`define FFR_CMD_PAGE_PROGRAM 8'h02
`define FFR_CMD_QUAD_PROGRAM 8'h33

// ****************************************
// Frame layout
// ****************************************
`define FFR_CMD_BITS 5'h08
`define FFR_ADDR_BITS 5'h18
`define FFR_CRM_SELECT 4'hA
`define FFR_DUAL_MODE_CLKS 4'h4
`define FFR_QUAD_MODE_CLKS 4'h2
`define FFR_DUAL_DUMMY 4'h4
`define FFR_QUAD_SPI_DUMMY 4'h6
`define FFR_QPI_DUMMY_4 4'h4
`define FFR_QPI_DUMMY_6 4'h6
`define FFR_QPI_DUMMY_8 4'h8
`define FFR_STATUS_PAD 6'h00
`define FFR_IDLE_BYTE 8'hFF

// ****************************************
// Wrap section masks within a page
// ****************************************
`define FFR_WRAP_MASK_8 8'h07
`define FFR_WRAP_MASK_16 8'h0F
`define FFR_WRAP_MASK_32 8'h1F
`define FFR_WRAP_MASK_64 8'h3F

// ****************************************
// Timing
// ****************************************
// Arbitrary program time in system clock cycles, sized for the parameter
`define FFR_PROG_CYCLES 24'h009C40

`endif

// ===== testbench/ffr_flash_seq_chk.sv
// ********************
// Port checker
// ********************
module ffr_flash_seq_chk #(
	parameter [23:0] PROG_CYCLES = 24'h009C40
) (
	// Clock and reset
	input wire clk_sys_i,
	input wire rst_b_i,
	// Link and configuration
	input wire link_cs_b_i,
	input wire [3:0] link_io_oe_o,
	input wire quad_lines_enable_bit_i,
	// Status and array
	input wire busy_o,
	input wire write_permit_latch_o,
	input wire continuous_read_o,
	input wire mem_rd_req_o,
	input wire mem_wr_en_o,
	input wire [23:0] mem_wr_addr_o
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [23:0] busy_cnt_reg;
	// Counter keeps the long program time out of a repetition
	always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
		if (!rst_b_i)
			busy_cnt_reg <= 24'h000000;
		else if (busy_o)
			busy_cnt_reg <= busy_cnt_reg + 24'h000001;
		else
			busy_cnt_reg <= 24'h000000;
	end
	default clocking cb @(posedge clk_sys_i); endclocking
	default disable iff (!rst_b_i);
	idle_quiet_a: assert property (
		link_cs_b_i [*8] |-> link_io_oe_o == 4'h0)
		else $error("lines driven while deselected");
	lane_set_a: assert property (
		link_io_oe_o == 4'hF |-> quad_lines_enable_bit_i)
		else $error("four lanes driven without quad enable");
	latch_drop_a: assert property (
		$rose(busy_o) |-> !write_permit_latch_o)
		else $error("latch still set while busy");
	busy_cause_a: assert property (
		$rose(busy_o) |-> $past(write_permit_latch_o) && link_cs_b_i)
		else $error("program started without permit");
	prog_time_a: assert property (
		$fell(busy_o) |-> busy_cnt_reg >= PROG_CYCLES - 24'h000002 &&
		busy_cnt_reg <= PROG_CYCLES + 24'h000002)
		else $error("program time wrong");
	scan_window_a: assert property (
		mem_wr_en_o |-> busy_o && busy_cnt_reg <= 24'h000102)
		else $error("array write outside program scan");
	page_order_a: assert property (
		mem_wr_en_o && $past(mem_wr_en_o) |->
		mem_wr_addr_o[23:8] == $past(mem_wr_addr_o[23:8]) &&
		mem_wr_addr_o[7:0] > $past(mem_wr_addr_o[7:0]))
		else $error("write left the page");
	crm_arm_a: assert property (
		$rose(continuous_read_o) |-> !link_cs_b_i && !busy_o)
		else $error("continuous read armed outside frame");
	rd_idle_a: assert property (
		mem_rd_req_o |-> !busy_o)
		else $error("array read while busy");
	cover property ($rose(busy_o));
	cover property ($rose(continuous_read_o));
	cover property (mem_wr_en_o && $past(mem_wr_en_o));
endmodule

bind ffr_flash_seq ffr_flash_seq_chk #(.PROG_CYCLES(PROG_CYCLES)) chk_i (
	.clk_sys_i(clk_sys_i), .rst_b_i(rst_b_i), .link_cs_b_i(link_cs_b_i),
	.link_io_oe_o(link_io_oe_o),
	.quad_lines_enable_bit_i(quad_lines_enable_bit_i), .busy_o(busy_o),
	.write_permit_latch_o(write_permit_latch_o),
	.continuous_read_o(continuous_read_o), .mem_rd_req_o(mem_rd_req_o),
	.mem_wr_en_o(mem_wr_en_o), .mem_wr_addr_o(mem_wr_addr_o)
);

// ===== testbench/ffr_host_mdl.sv
// ********************
// Serial host model
// ********************
module ffr_host_mdl (
	input wire logic clk_i,
	input wire logic [3:0] pin_i,
	output logic cs_b_o,
	output logic sck_o,
	output logic [3:0] io_o
);
	timeunit 1ns;
	timeprecision 1ps;
	initial begin
		cs_b_o = 1'b1;
		sck_o = 1'b0;
		io_o = 4'hF;
	end
	// Released lanes toggle every serial clock so a stale level never passes
	task automatic tk(input logic [3:0] v, input bit rel, output logic [3:0] r);
		@(negedge clk_i);
		sck_o = 1'b0;
		io_o = rel ? ~io_o : v;
		repeat (4) @(negedge clk_i);
		sck_o = 1'b1;
		repeat (3) @(negedge clk_i);
		r = pin_i;
	endtask
	task automatic sh(input logic [31:0] d, input int n, input int w);
		logic [3:0] r;
		for (int i = n - w; i >= 0; i -= w)
			tk(4'((d >> i) & ((1 << w) - 1)), 1'b0, r);
	endtask
	task automatic rb(input int w, output logic [7:0] b);
		logic [3:0] r;
		b = 8'h00;
		for (int i = 0; i < 8 / w; i++) begin
			tk(4'h0, 1'b1, r);
			b = 8'(b << w) | 8'(w == 1 ? r[1] : r & 4'((1 << w) - 1));
		end
	endtask
	task automatic dm(input int n);
		logic [3:0] r;
		repeat (n) tk(4'h0, 1'b1, r);
	endtask
	task automatic go();
		@(negedge clk_i);
		cs_b_o = 1'b0;
	endtask
	task automatic stop();
		@(negedge clk_i);
		sck_o = 1'b0;
		repeat (4) @(negedge clk_i);
		cs_b_o = 1'b1;
		io_o = ~io_o;
		repeat (12) @(negedge clk_i);
	endtask
endmodule

// ===== testbench/testbench.sv
module testbench;
	timeunit 1ns;
	timeprecision 1ps;
	// ********************
	// Bench signals
	// ********************
	localparam [23:0] PROG = 24'h00012C;
	logic clk_sys_i, rst_b_i, qe, fw, wen, cs_b, sck, busy, wpl, crm;
	logic rq, ack, wr;
	logic [1:0] wl, ds;
	logic [3:0] h_io, d_io, d_oe, pin;
	logic [23:0] ra, wa, a;
	logic [7:0] rdat, wdat;
	int bad_count, samples_checked, cyc, nrd, n0, seed;
	logic [31:0] expq[$];
	assign pin = (d_oe & d_io) | (~d_oe & h_io);
	ffr_flash_seq #(.PROG_CYCLES(PROG)) DUT (
		.clk_sys_i(clk_sys_i), .rst_b_i(rst_b_i), .link_cs_b_i(cs_b),
		.link_sck_i(sck), .link_io_i(pin), .link_io_o(d_io),
		.link_io_oe_o(d_oe), .quad_lines_enable_bit_i(qe),
		.four_wire_command_mode_i(fw), .wrap_enable_i(wen),
		.wrap_len_sel_i(wl), .dummy_sel_i(ds), .busy_o(busy),
		.write_permit_latch_o(wpl), .continuous_read_o(crm),
		.mem_rd_req_o(rq), .mem_rd_addr_o(ra), .mem_rd_ack_i(ack),
		.mem_rd_data_i(rdat), .mem_wr_en_o(wr), .mem_wr_addr_o(wa),
		.mem_wr_data_o(wdat)
	);
	ffr_host_mdl host (.clk_i(clk_sys_i), .pin_i(pin), .cs_b_o(cs_b),
		.sck_o(sck), .io_o(h_io));
	initial begin
		clk_sys_i = 1'b0;
		forever #12.5 clk_sys_i = ~clk_sys_i;
	end
	function automatic logic [7:0] mv(input logic [23:0] x);
		return x[7:0] ^ x[15:8] ^ 8'h5A;
	endfunction
	// ********************
	// Array and watcher
	// ********************
	always @(negedge clk_sys_i) begin
		ack <= rq;
		if (rq)
			rdat <= mv(ra);
	end
	// Outputs are looked at mid-cycle, away from the edge that moves them
	always @(negedge clk_sys_i) begin
		cyc <= cyc + 1;
		if (rq)
			nrd <= nrd + 1;
		if (wr)
			chk({wa, wdat}, expq.size() ? expq.pop_front() : 32'hX);
		if (cyc == 40000) begin
			bad_count++;
			finish_test();
		end
	end
	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		samples_checked++;
		if (g !== e) begin
			bad_count++;
			$display("[FAIL] %0t got %h want %h", $time, g, e);
		end
	endtask
	task automatic finish_test();
		$display("compares %0d mismatches %0d", samples_checked, bad_count);
		if (bad_count == 0 && samples_checked > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	// ********************
	// Frames
	// ********************
	task automatic stat(input logic [7:0] e);
		logic [7:0] s;
		host.go();
		host.sh(32'h05, 8, 1);
		host.rb(1, s);
		host.stop();
		chk(s, e);
	endtask
	task automatic wp();
		host.go();
		host.sh(32'h06, 8, 1);
		host.stop();
	endtask
	task automatic prog(input logic [7:0] c, input int w, n, p, input bit ok);
		logic [7:0] pg[256];
		bit v[256];
		logic [7:0] d;
		host.go();
		host.sh(c, 8, 1);
		host.sh(a, 24, w);
		for (int i = 0; i < n; i++) begin
			d = 8'($random(seed));
			host.sh(d, 8, w);
			pg[8'(a[7:0] + i)] = d;
			v[8'(a[7:0] + i)] = 1'b1;
		end
		host.sh(32'h0, p, w);
		// Queue before deselect: the scan starts a few clocks after it
		for (int i = 0; i < 256; i++)
			if (ok && v[i])
				expq.push_back({a[23:8], 8'(i), pg[i]});
		host.stop();
	endtask
	task automatic rdf(input logic [7:0] c, input bit cmd, input int w,
		input logic [23:0] x, input logic [7:0] m, input int d, n,
		input logic [7:0] wm);
		logic [7:0] b;
		host.go();
		if (cmd)
			host.sh(c, 8, fw ? 4 : 1);
		host.sh(x, 24, w);
		host.sh(m, 8, w);
		host.dm(d - 8 / w);
		for (int i = 0; i < n; i++) begin
			host.rb(w, b);
			chk(b, mv(x));
			x = wm == 0 ? x + 1 : {x[23:8], x[7:0] & ~wm | 8'(x[7:0] + 1) & wm};
		end
		host.stop();
	endtask
	task automatic idle();
		int k;
		for (k = 0; k < 400 && busy !== 1'b0; k++)
			@(negedge clk_sys_i);
		chk(k < 400, 1);
	endtask
	// ********************
	// Main sequence
	// ********************
	initial begin
		{rst_b_i, qe, fw, wen, wl, ds, ack, rdat} = '0;
		{bad_count, samples_checked, cyc, nrd} = '0;
		seed = 47834;
		repeat (4) @(negedge clk_sys_i);
		rst_b_i = 1'b1;
		repeat (6) @(negedge clk_sys_i);
		chk({busy, wpl, crm, d_oe}, 0);
		stat(8'h00);
		wp();
		stat(8'h02);
		a = {16'($random(seed)), 8'hFE};
		prog(8'h02, 1, 3, 0, 1);
		chk({busy, wpl}, 2'b10);
		stat(8'h01);
		idle();
		prog(8'h02, 1, 2, 0, 0);
		chk(busy, 0);
		wp();
		prog(8'h02, 1, 1, 4, 0);
		chk(busy, 0);
		qe = 1'b1;
		wp();
		prog(8'h33, 4, 2, 0, 1);
		chk(busy, 1);
		idle();
		chk(expq.size(), 0);
		$display("done: program");
		rdf(8'hEB, 1, 4, a, 8'hA5, 6, 2, 0);
		chk(crm, 1);
		rdf(8'h00, 0, 4, a + 24'h000010, 8'h5A, 6, 2, 0);
		chk(crm, 0);
		rdf(8'hBB, 1, 2, a, 8'hA3, 4, 2, 0);
		chk(crm, 1);
		rdf(8'h00, 0, 2, a, 8'h00, 4, 1, 0);
		chk(crm, 0);
		wen = 1'b1;
		for (int k = 0; k < 4; k++) begin
			wl = 2'(k);
			rdf(8'hEB, 1, 4, a - 24'h3, 8'h00, 6, 8, 8'((8 << k) - 1));
		end
		rdf(8'hEB, 1, 4, a, 8'hA5, 6, 1, 0);
		chk(crm, 1);
		// All-ones address clocks then deselect leave continuous mode
		host.go();
		host.sh(32'hFF, 8, 4);
		host.stop();
		chk(crm, 0);
		fw = 1'b1;
		for (int k = 0; k < 4; k++) begin
			ds = 2'(k);
			rdf(8'hEB, 1, 4, a, 8'h00, k < 2 ? 4 : 2 * k + 2, 4, 0);
		end
		rdf(8'hEB, 1, 4, a, 8'hA0, 8, 1, 0);
		chk(crm, 1);
		rdf(8'h00, 0, 4, a, 8'h00, 8, 1, 0);
		chk(crm, 0);
		{qe, fw} = 2'b00;
		n0 = nrd;
		host.go();
		host.sh(32'hEB, 8, 1);
		host.sh(a, 24, 4);
		host.dm(8);
		host.stop();
		chk(nrd - n0, 0);
		$display("done: reads");
		finish_test();
	end
endmodule
